/* rf_lock_pkg.sv */
/*
 Constants and types shared by the synthesiser lock reporting logic:
 register addresses, field positions, reset values and tolerance counts.
 Assumes an 8-bit serial register address and 16-bit register words.
*/
`default_nettype none

package rf_lock_pkg;

    localparam int NUM_SYNTH   = 2;
    localparam int ADDR_BITS   = 8;
    localparam int DATA_BITS   = 16;
    localparam int HISTORY_LEN = 3;
    localparam int CNT_BITS    = 3;

    localparam logic [7:0] ADDR_BUS_RESET   = 8'h01;
    localparam logic [7:0] ADDR_DIV_DATA    = 8'hB2;
    localparam logic [7:0] ADDR_SYNTH_CTRL  = 8'hB3;
    localparam logic [7:0] ADDR_LOCK_STATUS = 8'hB4;
    localparam logic [7:0] ADDR_IRQ_STATUS  = 8'hC6;
    localparam logic [7:0] ADDR_IRQ_MASK    = 8'hCE;

    // Serial frame bit counts: address byte, then a 16-bit word
    localparam logic [4:0] LAST_ADDR_BIT = 5'h07;
    localparam logic [4:0] LAST_WORD_BIT = 5'h17;

    // Tolerance in undivided reference clock cycles
    localparam logic [CNT_BITS-1:0] TOL_ONE  = 3'h1;
    localparam logic [CNT_BITS-1:0] TOL_FOUR = 3'h4;
    localparam logic [CNT_BITS-1:0] CNT_MAX  = 3'h7;

    // Interrupt status / mask bit positions
    localparam int IRQ_LOSS_LSB = 0;
    localparam int IRQ_GAIN_LSB = 2;

    localparam logic [15:0] DIV_DATA_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] MASK_RESET     = 16'h0000;
    localparam logic [15:0] IRQ_RESET      = 16'h0000;

    // One byte of the control register per synthesiser
    typedef struct packed {
        logic [3:0] upper;
        logic       gainHigh;
        logic       spare;
        logic       tolFour;
        logic       enable;
    } synth_ctrl_t;

    typedef struct packed {
        logic locked;
        logic measDone;
        logic measOk;
    } lock_report_t;

endpackage

`default_nettype wire

/* lock_vote_detector.sv */
/*
 Phase lock detector for one synthesiser with a three-deep majority vote.
 Assumes one-cycle pulses for the reference and feedback divider edges and
 for each rising edge of the undivided reference clock, all on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module lock_vote_detector (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire rf_lock_pkg::synth_ctrl_t ctrl,
    input  wire logic                 refTick,
    input  wire logic                 refEdge,
    input  wire logic                 fbEdge,
    output rf_lock_pkg::lock_report_t report
);

    typedef enum logic [1:0] {IDLE, WAIT_FB, WAIT_REF} meas_state_t;

    meas_state_t                       state_ff;
    meas_state_t                       nxt_state;
    logic [rf_lock_pkg::CNT_BITS-1:0]  cnt_ff;
    logic [rf_lock_pkg::CNT_BITS-1:0]  nxt_cnt;
    logic [rf_lock_pkg::HISTORY_LEN-1:0] history_ff;
    logic                              locked_ff;
    logic                              measDone_ff;
    logic                              measOk_ff;
    logic                              measure;
    logic                              ok;
    wire  logic [rf_lock_pkg::CNT_BITS-1:0] cntNow;
    wire  logic [rf_lock_pkg::CNT_BITS-1:0] tol;
    wire  logic                        inTol;
    wire  logic [rf_lock_pkg::HISTORY_LEN-1:0] nxtHistory;

    function automatic logic maj3(input logic [2:0] h);
        maj3 = (h[0] & h[1]) | (h[0] & h[2]) | (h[1] & h[2]);
    endfunction

    // Count edges of the raw reference, never the comparison clock
    assign cntNow = (refTick && cnt_ff != rf_lock_pkg::CNT_MAX)
                  ? cnt_ff + 3'h1 : cnt_ff;
    assign tol    = ctrl.tolFour ? rf_lock_pkg::TOL_FOUR
                                 : rf_lock_pkg::TOL_ONE;
    // Phase agreement only; a frequency error just shows as misses
    assign inTol  = cntNow <= tol;
    assign nxtHistory = {history_ff[1:0], ok};

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cntNow;
        measure   = 1'b0;
        ok        = 1'b0;
        case (state_ff)
            IDLE: begin
                nxt_cnt = '0;
                if (refEdge && fbEdge) begin
                    measure = 1'b1;
                    ok      = 1'b1;
                end else if (refEdge) begin
                    nxt_state = WAIT_FB;
                end else if (fbEdge) begin
                    nxt_state = WAIT_REF;
                end
            end
            WAIT_FB: begin
                if (fbEdge) begin
                    measure   = 1'b1;
                    ok        = inTol;
                    nxt_state = IDLE;
                end else if (refEdge) begin
                    // A second reference edge first is a missed cycle
                    measure = 1'b1;
                    nxt_cnt = '0;
                end
            end
            WAIT_REF: begin
                if (refEdge) begin
                    measure   = 1'b1;
                    ok        = inTol;
                    nxt_state = IDLE;
                end else if (fbEdge) begin
                    measure = 1'b1;
                    nxt_cnt = '0;
                end
            end
            default: begin
                nxt_state = IDLE;
                nxt_cnt   = '0;
            end
        endcase
        if (!ctrl.enable) begin
            nxt_state = IDLE;
            nxt_cnt   = '0;
            measure   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !ctrl.enable) begin
            state_ff    <= IDLE;
            cnt_ff      <= '0;
            history_ff  <= '0;
            locked_ff   <= 1'b0;
            measDone_ff <= 1'b0;
            measOk_ff   <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            measDone_ff <= measure;
            measOk_ff   <= ok;
            if (measure) begin
                history_ff <= nxtHistory;
                locked_ff  <= maj3(nxtHistory);
            end
        end
    end

    assign report = '{locked: locked_ff, measDone: measDone_ff,
                      measOk: measOk_ff};

    sequence measTaken;
        measure && ctrl.enable;
    endsequence

    lock_majority_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        measTaken |=> locked_ff == maj3(history_ff))
        else $error("lock flag is not the majority of history");

    history_shift_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        measTaken |=> history_ff[0] == $past(ok)
                      && history_ff[2:1] == $past(history_ff[1:0]))
        else $error("history did not shift in the measurement");

    tol_one_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ctrl.enable && !ctrl.tolFour && state_ff == WAIT_FB && fbEdge
         && cntNow > 3'h1) |=> !history_ff[0])
        else $error("error beyond one cycle judged in lock");

    tick_count_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (ctrl.enable && state_ff != IDLE && !refTick && !measure
         && nxt_state == state_ff) |=> $stable(cnt_ff))
        else $error("window count moved without a reference edge");

    disable_clear_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !ctrl.enable |=> !locked_ff && history_ff == 3'h0)
        else $error("disabled detector still reports lock");

endmodule // lock_vote_detector

`default_nettype wire

/* rf_synth_lock_detector.sv */
/*
 Lock reporting for two synthesisers behind the serial control bus.
 Holds the divider data, control, lock status, interrupt status and mask
 registers. Assumes serial bus pins and divider edges are synchronous to
 clk_sys and that clk_sys is much faster than the reference clock.
*/
`timescale 1ns/1ps
`default_nettype none

module rf_synth_lock_detector (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        csN,
    input  wire logic        serClk,
    input  wire logic        cmdData,
    output logic             replyData,
    output logic             replyOe,
    output logic             irqN,
    input  wire logic        refClk,
    input  wire logic [1:0]  refDivEdge,
    input  wire logic [1:0]  fbDivEdge,
    output logic [15:0]      dividerData,
    output logic             dividerLoad,
    output logic [15:0]      synthCtrl,
    output logic [1:0]       locked
);

    logic        serClkPrev_ff;
    logic        refPrev_ff;
    logic [4:0]  bitCnt_ff;
    logic [22:0] shiftIn_ff;
    logic [15:0] replyShift_ff;
    logic        reading_ff;
    logic [15:0] divData_ff;
    logic        divLoad_ff;
    logic [15:0] ctrl_ff;
    logic [15:0] mask_ff;
    logic [15:0] irqStatus_ff;
    logic [15:0] nxt_irqStatus;
    logic [1:0]  lockedPrev_ff;
    logic        irqN_ff;

    rf_lock_pkg::lock_report_t report [rf_lock_pkg::NUM_SYNTH];
    wire logic [1:0] lockNow;

    wire logic       serRise  = serClk & ~serClkPrev_ff & ~csN;
    wire logic       serFall  = ~serClk & serClkPrev_ff & ~csN;
    wire logic       refTick  = refClk & ~refPrev_ff;
    wire logic       addrDone = serRise
                                && bitCnt_ff == rf_lock_pkg::LAST_ADDR_BIT;
    wire logic       wordDone = serRise
                                && bitCnt_ff == rf_lock_pkg::LAST_WORD_BIT;
    wire logic [7:0] addrNow  = {shiftIn_ff[6:0], cmdData};
    wire logic [7:0] wordAddr = shiftIn_ff[22:15];
    wire logic [15:0] wordNow = {shiftIn_ff[14:0], cmdData};
    wire logic       busReset = addrDone
                                && addrNow == rf_lock_pkg::ADDR_BUS_RESET;

    wire logic wrData = wordDone && wordAddr == rf_lock_pkg::ADDR_DIV_DATA;
    wire logic wrCtrl = wordDone && wordAddr == rf_lock_pkg::ADDR_SYNTH_CTRL;
    wire logic wrMask = wordDone && wordAddr == rf_lock_pkg::ADDR_IRQ_MASK;
    wire logic rdStat = addrDone && addrNow == rf_lock_pkg::ADDR_LOCK_STATUS;
    wire logic rdIrq  = addrDone && addrNow == rf_lock_pkg::ADDR_IRQ_STATUS;

    // 8-bit status sits in the upper byte so it leaves first
    wire logic [15:0] statusWord = {6'h00, lockNow, 8'h00};
    // Unlisted addresses answer zero rather than test data
    wire logic [15:0] readWord = rdStat ? statusWord
                               : rdIrq  ? irqStatus_ff : 16'h0000;

    // Events: loss of lock and gain of lock, per synthesiser
    wire logic [1:0]  lossEvt = lockedPrev_ff & ~lockNow;
    wire logic [1:0]  gainEvt = ~lockedPrev_ff & lockNow;
    wire logic [15:0] setEvt  = 16'(lossEvt) << rf_lock_pkg::IRQ_LOSS_LSB
                              | 16'(gainEvt) << rf_lock_pkg::IRQ_GAIN_LSB;
    // Reading clears, but an event in the same cycle survives the read
    assign nxt_irqStatus = (rdIrq ? 16'h0000 : irqStatus_ff) | setEvt;

    genvar s;
    generate
        for (s = 0; s < rf_lock_pkg::NUM_SYNTH; s++) begin : g_synth
            lock_vote_detector u_det (
                .clk_sys (clk_sys),
                .reset   (reset),
                .ctrl    (rf_lock_pkg::synth_ctrl_t'(ctrl_ff[s*8 +: 8])),
                .refTick (refTick),
                .refEdge (refDivEdge[s]),
                .fbEdge  (fbDivEdge[s]),
                .report  (report[s])
            );
            assign lockNow[s] = report[s].locked;

            // Lock moves only on a reported measurement or a disable
            lock_moves_a: assert property (
                @(posedge clk_sys) disable iff (reset)
                $changed(lockNow[s]) |-> !$past(ctrl_ff[s*8])
                    || (report[s].measDone
                        && (report[s].measOk || !lockNow[s])))
                else $error("lock flag moved without a measurement");
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            serClkPrev_ff <= 1'b1;
            refPrev_ff    <= 1'b0;
            bitCnt_ff     <= '0;
            shiftIn_ff    <= '0;
        end else begin
            serClkPrev_ff <= serClk;
            refPrev_ff    <= refClk;
            if (csN) begin
                bitCnt_ff <= '0;
            end else if (serRise) begin
                shiftIn_ff <= {shiftIn_ff[21:0], cmdData};
                // Parks one past the last bit so extra bits repeat no write
                if (bitCnt_ff <= rf_lock_pkg::LAST_WORD_BIT)
                    bitCnt_ff <= bitCnt_ff + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            replyShift_ff <= '0;
            reading_ff    <= 1'b0;
        end else if (csN) begin
            reading_ff    <= 1'b0;
        end else if (addrDone) begin
            replyShift_ff <= readWord;
            reading_ff    <= rdStat | rdIrq;
        end else if (serFall && reading_ff) begin
            replyShift_ff <= {replyShift_ff[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || busReset) begin
            divData_ff <= rf_lock_pkg::DIV_DATA_RESET;
            divLoad_ff <= 1'b0;
            ctrl_ff    <= rf_lock_pkg::CTRL_RESET;
            mask_ff    <= rf_lock_pkg::MASK_RESET;
        end else begin
            divLoad_ff <= wrData;
            if (wrData)
                divData_ff <= wordNow;
            if (wrCtrl)
                ctrl_ff <= wordNow;
            if (wrMask)
                mask_ff <= wordNow;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqStatus_ff  <= rf_lock_pkg::IRQ_RESET;
            lockedPrev_ff <= 2'h0;
            irqN_ff       <= 1'b1;
        end else begin
            irqStatus_ff  <= nxt_irqStatus;
            lockedPrev_ff <= lockNow;
            irqN_ff       <= ~|(nxt_irqStatus & mask_ff);
        end
    end

    assign replyData   = replyShift_ff[15];
    assign replyOe     = reading_ff & ~csN;
    assign irqN        = irqN_ff;
    assign dividerData = divData_ff;
    assign dividerLoad = divLoad_ff;
    assign synthCtrl   = ctrl_ff;
    assign locked      = lockNow;

    sequence lockLost(int i);
        lockedPrev_ff[i] && !lockNow[i];
    endsequence

    loss_event_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        lockLost(0) |=> irqStatus_ff[rf_lock_pkg::IRQ_LOSS_LSB])
        else $error("loss of lock not recorded");

    loss_two_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        lockLost(1) |=> irqStatus_ff[rf_lock_pkg::IRQ_LOSS_LSB + 1])
        else $error("second synthesiser loss not recorded");

    irq_gate_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (gainEvt[0] && mask_ff[rf_lock_pkg::IRQ_GAIN_LSB] && !wrMask)
        |=> !irqN)
        else $error("unmasked lock event did not assert interrupt");

    irq_masked_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (mask_ff == 16'h0000 && !wrMask) |=> irqN)
        else $error("interrupt raised with all sources masked");

    status_read_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        rdStat |=> replyShift_ff == {6'h00, $past(lockNow), 8'h00}
                   && reading_ff)
        else $error("status read does not carry the lock flags");

    set_wins_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (rdIrq && lossEvt[0]) |=> irqStatus_ff[rf_lock_pkg::IRQ_LOSS_LSB])
        else $error("event lost in the clearing read");

    unlisted_zero_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (addrDone && !rdStat && !rdIrq) |=> replyShift_ff == 16'h0000
                                           && !replyOe)
        else $error("unlisted address produced a reply");

endmodule // rf_synth_lock_detector

`default_nettype wire

/* serial_host_model.sv */
/*
 Host side of the serial control bus: frames of address and data bits.
 Assumes clk_sys is the device clock; lines change at its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
    input  wire logic clk_sys,
    output logic      csN,
    output logic      serClk,
    output logic      cmdData,
    input  wire logic replyLine,
    input  wire logic replyOe
);
    initial begin
        csN     = 1'b1;
        serClk  = 1'b1;
        cmdData = 1'b0;
    end

    // Three cycles low and four or more high so edge detection and reply load both settle
    task automatic frame(input logic [7:0] a, input logic [15:0] w,
                         input int nb, input bit rd,
                         output logic [15:0] r, output logic oe);
        logic [23:0] sh;
        int          n;
        sh = {a, w};
        r  = 16'h0000;
        oe = 1'b0;
        n  = rd ? 7 + nb : 8 + nb;
        @(negedge clk_sys);
        csN = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk_sys);
            serClk  = 1'b0;
            // Unused data phase of a read toggles, never a stale level
            cmdData = (i < 8 || !rd) ? sh[23-i] : ~cmdData;
            repeat (3) @(negedge clk_sys);
            serClk = 1'b1;
            repeat (4) @(negedge clk_sys);
            if (rd && i >= 7) begin
                r  = {r[14:0], replyLine};
                oe = oe | replyOe;
            end
        end
        csN = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
endmodule // serial_host_model

`default_nettype wire

/* rf_synth_lock_detector_tb_top.sv */
/*
 Self-checking bench for the lock reporting block: register frames and
 divider edge stimulus with expected values. Assumes the host model file.
*/
`timescale 1ns/1ps
`default_nettype none

module rf_synth_lock_detector_tb_top;
    logic        clk_sys;
    logic        reset;
    logic        csN;
    logic        serClk;
    logic        cmdData;
    logic        replyData;
    logic        replyOe;
    logic        irqN;
    logic        refClk;
    logic [1:0]  refDivEdge;
    logic [1:0]  fbDivEdge;
    logic [15:0] dividerData;
    logic        dividerLoad;
    logic [15:0] synthCtrl;
    logic [1:0]  locked;
    logic        replyLine;
    logic [15:0] rdVal;
    logic        oeVal;
    int          n_errors;
    int          checks_done;
    int          loadCount;

    // Undriven reply line shows the inverse, never a held value
    assign replyLine = replyOe ? replyData : ~replyData;

    rf_synth_lock_detector DUT (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .csN        (csN),
        .serClk     (serClk),
        .cmdData    (cmdData),
        .replyData  (replyData),
        .replyOe    (replyOe),
        .irqN       (irqN),
        .refClk     (refClk),
        .refDivEdge (refDivEdge),
        .fbDivEdge  (fbDivEdge),
        .dividerData(dividerData),
        .dividerLoad(dividerLoad),
        .synthCtrl  (synthCtrl),
        .locked     (locked)
    );

    serial_host_model host (
        .clk_sys  (clk_sys),
        .csN      (csN),
        .serClk   (serClk),
        .cmdData  (cmdData),
        .replyLine(replyLine),
        .replyOe  (replyOe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Counts load strobes so a write is seen to pulse exactly once
    always @(posedge clk_sys) begin
        if (reset)
            loadCount <= 0;
        else if (dividerLoad)
            loadCount <= loadCount + 1;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        host.frame(a, w, 16, 1'b0, rdVal, oeVal);
    endtask

    task automatic rd(input logic [7:0] a, input int nb);
        host.frame(a, 16'h0000, nb, 1'b1, rdVal, oeVal);
    endtask

    // Window of n reference ticks between the two divider edges
    task automatic win(input int s, input int n, input bit fbFirst);
        @(negedge clk_sys);
        refDivEdge[s] = !fbFirst;
        fbDivEdge[s]  = fbFirst;
        @(negedge clk_sys);
        refDivEdge[s] = 1'b0;
        fbDivEdge[s]  = 1'b0;
        repeat (n) begin
            refClk = 1'b1;
            repeat (2) @(negedge clk_sys);
            refClk = 1'b0;
            repeat (2) @(negedge clk_sys);
        end
        repeat (2) @(negedge clk_sys);
        refDivEdge[s] = fbFirst;
        fbDivEdge[s]  = !fbFirst;
        @(negedge clk_sys);
        refDivEdge[s] = 1'b0;
        fbDivEdge[s]  = 1'b0;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic meas(input int s, input int n);
        win(s, n, 1'b0);
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end

    initial begin
        n_errors    = 0;
        checks_done = 0;
        reset       = 1'b1;
        refClk      = 1'b0;
        refDivEdge  = 2'b00;
        fbDivEdge   = 2'b00;
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        @(negedge clk_sys);
        chk({14'h0000, locked}, 16'h0000);
        chk({15'h0000, irqN}, 16'h0001);
        wr(8'hB2, 16'hA5C3);
        chk(dividerData, 16'hA5C3);
        chk(loadCount[15:0], 16'h0001);
        wr(8'hCE, 16'h000F);
        wr(8'hB3, 16'h0301);
        chk(synthCtrl, 16'h0301);
        chk(loadCount[15:0], 16'h0001);
        $display("test setup done");

        meas(0, 1);
        chk({14'h0000, locked}, 16'h0000);
        meas(0, 1);
        chk({14'h0000, locked}, 16'h0001);
        chk({15'h0000, irqN}, 16'h0000);
        rd(8'hB4, 8);
        chk(rdVal, 16'h0001);
        chk({15'h0000, oeVal}, 16'h0001);
        rd(8'hC6, 16);
        chk(rdVal, 16'h0004);
        chk({15'h0000, irqN}, 16'h0001);
        meas(0, 2);
        chk({14'h0000, locked}, 16'h0001);
        // Loss lands in the clearing read's address cycle: set must win
        fork
            begin
                repeat (48) @(negedge clk_sys);
                meas(0, 2);
            end
            rd(8'hC6, 16);
        join
        chk(rdVal, 16'h0000);
        chk({14'h0000, locked}, 16'h0000);
        chk({15'h0000, irqN}, 16'h0000);
        rd(8'hC6, 16);
        chk(rdVal, 16'h0001);
        $display("test tolerance one done");

        wr(8'hCE, 16'h0003);
        meas(1, 4);
        meas(1, 5);
        meas(1, 4);
        chk({14'h0000, locked}, 16'h0002);
        chk({15'h0000, irqN}, 16'h0001);
        meas(1, 5);
        chk({14'h0000, locked}, 16'h0000);
        chk({15'h0000, irqN}, 16'h0000);
        rd(8'hC6, 16);
        chk(rdVal, 16'h000A);
        $display("test tolerance four done");

        rd(8'hAF, 16);
        chk({15'h0000, oeVal}, 16'h0000);
        rd(8'hB3, 16);
        chk({15'h0000, oeVal}, 16'h0000);
        $display("test refused reads done");

        // Short windows without reference ticks still count as zero
        meas(0, 0);
        meas(0, 0);
        chk({14'h0000, locked}, 16'h0001);
        win(0, 2, 1'b1);
        win(0, 2, 1'b1);
        chk({14'h0000, locked}, 16'h0000);
        win(0, 1, 1'b1);
        win(0, 1, 1'b1);
        chk({14'h0000, locked}, 16'h0001);
        wr(8'hB3, 16'h0000);
        chk({14'h0000, locked}, 16'h0000);
        wr(8'hB3, 16'h0101);
        host.frame(8'h01, 16'h0000, 0, 1'b0, rdVal, oeVal);
        chk(synthCtrl, 16'h0000);
        chk(dividerData, 16'h0000);
        $display("test disable and bus reset done");
        final_report();
    end
endmodule // rf_synth_lock_detector_tb_top

`default_nettype wire
